//--- rtl/age_timer.sv
// Purpose: interval timer that paces address-table aging passes
// Assumes: restart pulses come from the aging sequencer
// Notes:   switching to normal takes effect at the next reload; switching to fast cuts a longer wait at once
`timescale 1ns/1ps
module age_timer #(
  parameter int              CNT_W      = 36,
  parameter logic [CNT_W-1:0] NORMAL_CYC = '1,
  parameter logic [CNT_W-1:0] FAST_CYC   = CNT_W'(1)
) (
  input  wire logic ref_clk, // core clock
  input  wire logic nrst,    // sync reset, low
  input  wire logic enable,  // count when high
  input  wire logic fast,    // use fast interval
  input  wire logic restart, // reload now
  output logic      tick     // one-cycle expiry
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] reload;
  logic             expired;

  generate
    if (FAST_CYC == '0 || NORMAL_CYC == '0 || FAST_CYC > NORMAL_CYC) begin : g_bad_cnt
      $error("age_timer intervals must be nonzero and fast not above normal");
    end
  endgenerate

  assign reload  = fast ? (FAST_CYC - 1'b1) : (NORMAL_CYC - 1'b1);
  assign expired = enable && (cnt_ff == '0);

  always_ff @(posedge ref_clk) begin
    if (!nrst || restart || !enable) begin
      cnt_ff <= reload;
    end else if (expired) begin
      cnt_ff <= reload;
    end else if (fast && cnt_ff > reload) begin
      // leave a long normal wait at once when fast aging is switched on
      cnt_ff <= reload;
    end else begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tick <= 1'b0;
    end else begin
      tick <= expired && !restart;
    end
  end

endmodule : age_timer

//--- rtl/frame_policy_cfg.svh
// Purpose: offsets, field positions, reset values and timing figures of the policy bank
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef FRAME_POLICY_CFG_SVH
`define FRAME_POLICY_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFF_GLOBAL_CONTROL_ZERO 8'h02
`define OFF_GLOBAL_CONTROL_ONE  8'h03
`define OFF_GLOBAL_CONTROL_TWO  8'h04

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define GC0_FC_DROP_SEL_BIT  1
`define GC0_LINK_AGE_BIT     0
`define GC1_PASS_ALL_BIT     7
`define GC1_TX_PAUSE_DIS_BIT 5
`define GC1_RX_PAUSE_DIS_BIT 4
`define GC1_LEN_CHECK_BIT    3
`define GC1_AGING_EN_BIT     2
`define GC1_FAST_AGE_BIT     1
`define GC1_BACKOFF_BIT      0
`define GC2_VLAN_DISCARD_BIT 7

// ---------------------------------------------------------------
// reset values of non-strap bits
// ---------------------------------------------------------------
`define RST_FC_DROP_SEL  1'h0
`define RST_LINK_AGE     1'h0
`define RST_PASS_ALL     1'h0
`define RST_LEN_CHECK    1'h0
`define RST_FAST_AGE     1'h0
`define RST_VLAN_DISCARD 1'h1

// ---------------------------------------------------------------
// frame constants and timing
// ---------------------------------------------------------------
`define PAUSE_ETHERTYPE  16'h8808
`define PAUSE_DEST_ADDR  48'h0180C2000001
`define LEN_CHECK_LIMIT  16'h05DC
`define CLK_HZ           40000000
`define FAST_AGE_US      800
`define AGE_NORMAL_S     300
`define AGE_SLACK_S      75

`endif

//--- rtl/frame_policy_pkg.sv
// Purpose: types shared by the policy bank
// Assumes: nothing
// Notes:   constants live in frame_policy_cfg.svh
package frame_policy_pkg;

  typedef enum logic [1:0] {
    AGE_IDLE,
    AGE_NORMAL_BUSY,
    AGE_FAST_BUSY
  } age_state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_ERRORED,
    CAUSE_FLOW_CTRL,
    CAUSE_LENGTH,
    CAUSE_VLAN
  } drop_cause_t;

endpackage : frame_policy_pkg

//--- rtl/strap_sync.sv
// Purpose: two-flop synchroniser for strap pins
// Assumes: pins are static around reset
// Notes:   no reset, so it settles while reset is still held
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,  // core clock
  input  wire logic [WIDTH-1:0] pin_in,   // raw pins
  output logic      [WIDTH-1:0] pin_sync  // synchronised level
);

  logic [WIDTH-1:0] meta_ff;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("strap_sync needs at least one pin");
    end
  endgenerate

  // first stage read only by second stage
  always_ff @(posedge ref_clk) begin
    meta_ff  <= pin_in;
    pin_sync <= meta_ff;
  end

endmodule : strap_sync

//--- rtl/switch_global_frame_policy.sv
// Purpose: global frame policy bank of a five-port switch
// Assumes: frame descriptors, link state and pass-done come from logic on ref_clk
// Notes:   strap pins are resampled for the whole of reset
// Operation
// - With drop select set, frames of type 0x8808 or to 01-80-C2-00-00-01 are dropped.
// - With drop select clear (reset), only qualified flow-control frames are dropped.
// - With link-change aging on, a link-down while no aging pass is running starts a fast aging pass under 800 us.
// - Once a fast pass is done with the fast age bit clear, aging returns to the normal 300 + 75 s period.
// - Unplugging any port ages out every learned address.
// - Pass-all forwards errored and length-mismatched frames, for sniffing; flow-control and VLAN drops still apply.
// - Transmit pause follows the negotiated result unless its disable bit is set.
// - Receive pause follows the negotiated result unless its disable bit is set.
// - Both pause disable bits reset from one strap and are then written separately.
// - With length check on, a frame with length below 1500 that mismatches is dropped.
// - The aging enable bit turns aging on and resets from its strap.
// - The fast age bit selects the 800 us aging period and resets to zero.
// - The backoff bit selects the aggressive half-duplex backoff.
// - The backoff bit resets from its strap, low meaning normal backoff.
// - With the VLAN discard bit set (reset), nothing crosses a port-VLAN boundary.
// - With it clear, only known unicast crosses a port-VLAN boundary.
`timescale 1ns/1ps
`include "frame_policy_cfg.svh"
module switch_global_frame_policy #(
  parameter int          PORTS          = 5,
  parameter int          CNT_W          = 36,
  parameter logic [35:0] FAST_AGE_CYC   = 36'((64'(`FAST_AGE_US) * 64'(`CLK_HZ)) / 64'd1000000),
  parameter logic [35:0] NORMAL_AGE_CYC =
    36'(64'(`AGE_NORMAL_S + `AGE_SLACK_S) * 64'(`CLK_HZ))
) (
  input  wire logic        ref_clk,                 // 40 MHz core clock
  input  wire logic        nrst,                    // sync reset, low
  // register access port
  input  wire logic [7:0]  reg_addr,                // register offset
  input  wire logic        reg_wr,                  // write strobe
  input  wire logic [7:0]  reg_wdata,               // write data
  input  wire logic        reg_rd,                  // read strobe
  output logic      [7:0]  reg_rdata,               // read data, next cycle
  // strap pins
  input  wire logic        pause_disable_strap_pin, // high disables pause
  input  wire logic        backoff_strap_pin,       // high aggressive backoff
  input  wire logic        aging_strap_pin,         // high aging enabled
  // frame descriptor from receive side
  input  wire logic        frm_valid,               // descriptor strobe
  input  wire logic [15:0] frm_type_len,            // type/length field
  input  wire logic [47:0] frm_dest_addr,           // destination address
  input  wire logic        frm_flow_ctrl,           // qualified flow-control frame
  input  wire logic        frm_errored,             // bad frame
  input  wire logic [15:0] frm_payload_len,         // measured payload bytes
  input  wire logic        frm_crosses_vlan,        // egress outside port-VLAN
  input  wire logic        frm_known_unicast,       // known unicast destination
  output logic             vrd_valid,               // verdict strobe
  output logic             vrd_drop,                // verdict: discard
  output frame_policy_pkg::drop_cause_t vrd_cause,  // why dropped
  // port state and pause
  input  wire logic [PORTS-1:0] link_up,            // per-port link
  input  wire logic [PORTS-1:0] autonegotiation_tx_pause, // negotiated tx pause
  input  wire logic [PORTS-1:0] autonegotiation_rx_pause, // negotiated rx pause
  output logic      [PORTS-1:0] tx_pause_en,        // tx pause in use
  output logic      [PORTS-1:0] rx_pause_en,        // rx pause in use
  output logic             aggressive_backoff,      // half-duplex backoff select
  // address table aging
  output logic             age_pass_req,            // start aging pass
  output logic             age_fast_mode,           // pass uses fast aging
  output logic             flush_all,               // age out all entries
  input  wire logic        age_pass_done            // pass finished
);
  import frame_policy_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (PORTS < 1 || PORTS > 8) begin : g_bad_ports
      $error("PORTS must be 1 to 8");
    end
    if (CNT_W != 36) begin : g_bad_cnt_w
      $error("CNT_W must match the 36-bit interval parameters");
    end
  endgenerate

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  logic [2:0] strap_sync_lvl;
  logic       pause_strap;
  logic       backoff_strap;
  logic       aging_strap;

  strap_sync #(
    .WIDTH (3)
  ) u_strap_sync (
    .ref_clk  (ref_clk),
    .pin_in   ({pause_disable_strap_pin, backoff_strap_pin, aging_strap_pin}),
    .pin_sync (strap_sync_lvl)
  );

  assign pause_strap   = strap_sync_lvl[2];
  assign backoff_strap = strap_sync_lvl[1];
  assign aging_strap   = strap_sync_lvl[0];

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  logic fc_drop_sel_ff;
  logic link_age_ff;
  logic pass_all_ff;
  logic tx_pause_dis_ff;
  logic rx_pause_dis_ff;
  logic len_check_ff;
  logic aging_en_ff;
  logic fast_age_ff;
  logic backoff_ff;
  logic vlan_discard_ff;

  logic wr_gc0;
  logic wr_gc1;
  logic wr_gc2;

  assign wr_gc0 = reg_wr && hit(reg_addr, `OFF_GLOBAL_CONTROL_ZERO);
  assign wr_gc1 = reg_wr && hit(reg_addr, `OFF_GLOBAL_CONTROL_ONE);
  assign wr_gc2 = reg_wr && hit(reg_addr, `OFF_GLOBAL_CONTROL_TWO);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fc_drop_sel_ff <= `RST_FC_DROP_SEL;
      link_age_ff    <= `RST_LINK_AGE;
    end else if (wr_gc0) begin
      fc_drop_sel_ff <= reg_wdata[`GC0_FC_DROP_SEL_BIT];
      link_age_ff    <= reg_wdata[`GC0_LINK_AGE_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pass_all_ff     <= `RST_PASS_ALL;
      len_check_ff    <= `RST_LEN_CHECK;
      fast_age_ff     <= `RST_FAST_AGE;
      tx_pause_dis_ff <= pause_strap;
      rx_pause_dis_ff <= pause_strap;
      aging_en_ff     <= aging_strap;
      backoff_ff      <= backoff_strap;
    end else if (wr_gc1) begin
      pass_all_ff     <= reg_wdata[`GC1_PASS_ALL_BIT];
      len_check_ff    <= reg_wdata[`GC1_LEN_CHECK_BIT];
      fast_age_ff     <= reg_wdata[`GC1_FAST_AGE_BIT];
      tx_pause_dis_ff <= reg_wdata[`GC1_TX_PAUSE_DIS_BIT];
      rx_pause_dis_ff <= reg_wdata[`GC1_RX_PAUSE_DIS_BIT];
      aging_en_ff     <= reg_wdata[`GC1_AGING_EN_BIT];
      backoff_ff      <= reg_wdata[`GC1_BACKOFF_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      vlan_discard_ff <= `RST_VLAN_DISCARD;
    end else if (wr_gc2) begin
      vlan_discard_ff <= reg_wdata[`GC2_VLAN_DISCARD_BIT];
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [7:0] gc0_view;
  logic [7:0] gc1_view;
  logic [7:0] gc2_view;
  logic [7:0] rd_mux;

  // unheld bits read as zero
  always_comb begin
    gc0_view = 8'h00;
    gc1_view = 8'h00;
    gc2_view = 8'h00;
    gc0_view[`GC0_FC_DROP_SEL_BIT]  = fc_drop_sel_ff;
    gc0_view[`GC0_LINK_AGE_BIT]     = link_age_ff;
    gc1_view[`GC1_PASS_ALL_BIT]     = pass_all_ff;
    gc1_view[`GC1_TX_PAUSE_DIS_BIT] = tx_pause_dis_ff;
    gc1_view[`GC1_RX_PAUSE_DIS_BIT] = rx_pause_dis_ff;
    gc1_view[`GC1_LEN_CHECK_BIT]    = len_check_ff;
    gc1_view[`GC1_AGING_EN_BIT]     = aging_en_ff;
    gc1_view[`GC1_FAST_AGE_BIT]     = fast_age_ff;
    gc1_view[`GC1_BACKOFF_BIT]      = backoff_ff;
    gc2_view[`GC2_VLAN_DISCARD_BIT] = vlan_discard_ff;
  end

  assign rd_mux = hit(reg_addr, `OFF_GLOBAL_CONTROL_ZERO) ? gc0_view :
                  hit(reg_addr, `OFF_GLOBAL_CONTROL_ONE)  ? gc1_view :
                  hit(reg_addr, `OFF_GLOBAL_CONTROL_TWO)  ? gc2_view : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // frame verdict
  // ---------------------------------------------------------------
  logic        is_pause_like;
  logic        drop_flow;
  logic        drop_len;
  logic        drop_err;
  logic        drop_vlan;
  drop_cause_t cause_sel;

  assign is_pause_like = (frm_type_len == `PAUSE_ETHERTYPE) ||
                         (frm_dest_addr == `PAUSE_DEST_ADDR);
  assign drop_flow     = fc_drop_sel_ff ? is_pause_like : frm_flow_ctrl;

  assign drop_len = len_check_ff && (frm_type_len < `LEN_CHECK_LIMIT) &&
                    (frm_payload_len != frm_type_len) && !pass_all_ff;

  assign drop_err = frm_errored && !pass_all_ff;

  assign drop_vlan = frm_crosses_vlan && (vlan_discard_ff || !frm_known_unicast);

  // errors first so, with pass-all clear, a bad frame is never reported as a policy drop
  assign cause_sel = drop_err  ? CAUSE_ERRORED   :
                     drop_flow ? CAUSE_FLOW_CTRL :
                     drop_len  ? CAUSE_LENGTH    :
                     drop_vlan ? CAUSE_VLAN      : CAUSE_NONE;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      vrd_valid <= 1'b0;
      vrd_drop  <= 1'b0;
      vrd_cause <= CAUSE_NONE;
    end else begin
      vrd_valid <= frm_valid;
      if (frm_valid) begin
        vrd_drop  <= (cause_sel != CAUSE_NONE);
        vrd_cause <= cause_sel;
      end
    end
  end

  // ---------------------------------------------------------------
  // pause and backoff
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_pause_en        <= '0;
      rx_pause_en        <= '0;
      aggressive_backoff <= 1'b0;
    end else begin
      tx_pause_en        <= autonegotiation_tx_pause & {PORTS{!tx_pause_dis_ff}};
      rx_pause_en        <= autonegotiation_rx_pause & {PORTS{!rx_pause_dis_ff}};
      aggressive_backoff <= backoff_ff;
    end
  end

  // ---------------------------------------------------------------
  // address aging
  // ---------------------------------------------------------------
  logic [PORTS-1:0] link_prev_ff;
  logic             link_lost;
  logic             link_fast_start;
  logic             age_tick;
  logic             timer_restart;
  age_state_t       age_state_ff;
  age_state_t       nxt_age_state;

  // links start down after reset, so coming up never looks like a loss
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      link_prev_ff <= '0;
    end else begin
      link_prev_ff <= link_up;
    end
  end

  assign link_lost       = |(link_prev_ff & ~link_up);
  assign link_fast_start = link_lost && link_age_ff;
  assign timer_restart   = age_pass_done;

  age_timer #(
    .CNT_W      (CNT_W),
    .NORMAL_CYC (NORMAL_AGE_CYC),
    .FAST_CYC   (FAST_AGE_CYC)
  ) u_age_timer (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .enable  (aging_en_ff && age_state_ff == AGE_IDLE),
    .fast    (fast_age_ff),
    .restart (timer_restart),
    .tick    (age_tick)
  );

  always_comb begin
    nxt_age_state = age_state_ff;
    unique case (age_state_ff)
      AGE_IDLE: begin
        if (link_fast_start) begin
          nxt_age_state = AGE_FAST_BUSY;
        end else if (age_tick) begin
          nxt_age_state = fast_age_ff ? AGE_FAST_BUSY : AGE_NORMAL_BUSY;
        end
      end
      AGE_NORMAL_BUSY: begin
        if (age_pass_done) begin
          nxt_age_state = AGE_IDLE;
        end
      end
      AGE_FAST_BUSY: begin
        if (age_pass_done) begin
          nxt_age_state = AGE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      age_state_ff  <= AGE_IDLE;
      age_pass_req  <= 1'b0;
      age_fast_mode <= 1'b0;
      flush_all     <= 1'b0;
    end else begin
      age_state_ff  <= nxt_age_state;
      age_pass_req  <= (age_state_ff == AGE_IDLE) && (nxt_age_state != AGE_IDLE);
      age_fast_mode <= (nxt_age_state == AGE_FAST_BUSY);
      flush_all     <= link_lost;
    end
  end

endmodule : switch_global_frame_policy

//--- testbench/switch_global_frame_policy_assertions.sv
// Purpose: port-level checks of the global frame policy bank
// Assumes: one ref_clk domain, synchronous active-low nrst
// Notes:   sees only the top-level ports, attached by bind
`timescale 1ns/1ps
module switch_global_frame_policy_assertions #(
  parameter int PORTS = 5
) (
  input wire logic             ref_clk,                  // core clock
  input wire logic             nrst,                     // sync reset, low
  input wire logic [7:0]       reg_addr,                 // register offset
  input wire logic             reg_wr,                   // write strobe
  input wire logic [7:0]       reg_wdata,                // write data
  input wire logic             frm_valid,                // descriptor strobe
  input wire logic             vrd_valid,                // verdict strobe
  input wire logic [PORTS-1:0] link_up,                  // per-port link
  input wire logic [PORTS-1:0] autonegotiation_tx_pause, // negotiated tx pause
  input wire logic [PORTS-1:0] tx_pause_en,              // tx pause in use
  input wire logic [PORTS-1:0] rx_pause_en,              // rx pause in use
  input wire logic             aggressive_backoff,       // backoff select
  input wire logic             age_pass_req,             // start pass
  input wire logic             age_fast_mode,            // fast pass
  input wire logic             flush_all,                // age out all
  input wire logic             age_pass_done             // pass finished
);
  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_verdict_next_cycle: assert property (frm_valid |=> vrd_valid)
    else $error("verdict strobe missing after descriptor");
  a_verdict_no_spurious: assert property (!frm_valid |=> !vrd_valid)
    else $error("verdict strobe without descriptor");
  a_tx_pause_subset: assert property (
    $past(nrst) |-> (tx_pause_en & ~$past(autonegotiation_tx_pause)) == '0)
    else $error("tx pause on without negotiation");
  a_tx_pause_off: assert property (
    reg_wr && reg_addr == 8'h03 && reg_wdata[5] |=> ##1 tx_pause_en == '0)
    else $error("tx pause still on after disable");
  a_rx_pause_off: assert property (
    reg_wr && reg_addr == 8'h03 && reg_wdata[4] |=> ##1 rx_pause_en == '0)
    else $error("rx pause still on after disable");
  a_backoff_follows_write: assert property (
    reg_wr && reg_addr == 8'h03 |=> ##1 aggressive_backoff == $past(reg_wdata[0], 2))
    else $error("backoff select not taken from write");
  a_flush_on_loss: assert property (
    $past(nrst) && |($past(link_up) & ~link_up) |=> flush_all)
    else $error("no flush after link loss");
  a_fast_starts_pass: assert property ($rose(age_fast_mode) |-> age_pass_req)
    else $error("fast mode raised without pass request");
  a_req_single_pulse: assert property (age_pass_req |=> !age_pass_req)
    else $error("pass request longer than one cycle");
  a_fast_ends_done: assert property (
    age_pass_done && age_fast_mode |=> !age_fast_mode)
    else $error("fast mode kept after pass done");
endmodule : switch_global_frame_policy_assertions

//--- testbench/test_switch_global_frame_policy.sv
// Purpose: self-checking bench of the global frame policy bank
// Assumes: timer counts shortened to 4 and 16 cycles
// Notes:   inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module test_switch_global_frame_policy;
  import frame_policy_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        ref_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        p_strap = 1'h0, b_strap = 1'h0, a_strap = 1'h0;
  logic        frm_valid = 1'h0, fc = 1'h0, err = 1'h0, crs = 1'h0, ku = 1'h0;
  logic [15:0] tl = 16'h0000, pl = 16'h0000;
  logic [47:0] da = 48'h000000000000;
  logic        vrd_valid, vrd_drop, aggressive_backoff, age_pass_req, age_fast_mode, flush_all;
  drop_cause_t vrd_cause;
  logic [4:0]  link_up = 5'h00, an_tx = 5'h15, an_rx = 5'h0A, tx_pause_en, rx_pause_en;
  logic        age_pass_done = 1'h0;
  int          n_fail = 0, n_tests = 0, n;

  always #12.5 ref_clk = ~ref_clk;

  switch_global_frame_policy #(.FAST_AGE_CYC(36'h4), .NORMAL_AGE_CYC(36'h10)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pause_disable_strap_pin(p_strap), .backoff_strap_pin(b_strap), .aging_strap_pin(a_strap),
    .frm_valid(frm_valid), .frm_type_len(tl), .frm_dest_addr(da), .frm_flow_ctrl(fc),
    .frm_errored(err), .frm_payload_len(pl), .frm_crosses_vlan(crs),
    .frm_known_unicast(ku), .vrd_valid(vrd_valid), .vrd_drop(vrd_drop),
    .vrd_cause(vrd_cause), .link_up(link_up), .autonegotiation_tx_pause(an_tx),
    .autonegotiation_rx_pause(an_rx), .tx_pause_en(tx_pause_en), .rx_pause_en(rx_pause_en),
    .aggressive_backoff(aggressive_backoff), .age_pass_req(age_pass_req),
    .age_fast_mode(age_fast_mode), .flush_all(flush_all), .age_pass_done(age_pass_done));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rst(input logic p, input logic b, input logic a);
    @(posedge ref_clk);
    nrst    <= 1'h0;
    p_strap <= p;
    b_strap <= b;
    a_strap <= a;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : rst

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rd

  // pause outputs and backoff, two edges after a write
  task automatic outs(input logic [4:0] t, input logic [4:0] r, input logic b);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({11'h000, tx_pause_en}, {11'h000, t});
    chk({11'h000, rx_pause_en}, {11'h000, r});
    chk({15'h0000, aggressive_backoff}, {15'h0000, b});
  endtask : outs

  task automatic frame(input logic [15:0] t, input logic [47:0] d, input logic [3:0] f,
                       input logic [15:0] p, input logic dr, input drop_cause_t ca);
    @(posedge ref_clk);
    frm_valid <= 1'h1;
    tl        <= t;
    da        <= d;
    pl        <= p;
    {fc, err, crs, ku} <= f;
    @(posedge ref_clk);
    frm_valid <= 1'h0;
    #1;
    chk({15'h0000, vrd_valid}, 16'h0001);
    chk({15'h0000, vrd_drop}, {15'h0000, dr});
    chk({13'h0000, vrd_cause}, {13'h0000, ca});
  endtask : frame

  task automatic wait_req(input int lim);
    n = 0;
    while (age_pass_req !== 1'h1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        n_fail++;
        $display("unexpected at %0t: got %h expected %h", $time, n, lim);
        tally_and_finish();
      end
    end
  endtask : wait_req

  task automatic done_pulse();
    @(posedge ref_clk);
    age_pass_done <= 1'h1;
    @(posedge ref_clk);
    age_pass_done <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk({15'h0000, age_fast_mode}, 16'h0000);
  endtask : done_pulse

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst(1'h1, 1'h1, 1'h0);
    outs(5'h00, 5'h00, 1'h1);
    rd(8'h03, 8'h31);
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h80);
    rst(1'h0, 1'h0, 1'h1);
    rd(8'h03, 8'h04);
    wr(8'h03, 8'h08);
    outs(5'h15, 5'h0A, 1'h0);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(8'h02, 8'hFE);
    rd(8'h02, 8'h02);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h80);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h28);
    outs(5'h00, 5'h0A, 1'h0);
    wr(8'h03, 8'h18);
    outs(5'h15, 5'h00, 1'h0);
    wr(8'h03, 8'h49);
    rd(8'h03, 8'h09);
    outs(5'h15, 5'h0A, 1'h1);
    wr(8'h03, 8'h08);
    frame(16'h8808, 48'h020000000001, 4'h0, 16'h0, 1'h0, CAUSE_NONE);
    frame(16'h0800, 48'h020000000001, 4'h8, 16'h0, 1'h1, CAUSE_FLOW_CTRL);
    frame(16'h0040, 48'h020000000001, 4'h0, 16'h41, 1'h1, CAUSE_LENGTH);
    frame(16'h05DC, 48'h020000000001, 4'h0, 16'h0, 1'h0, CAUSE_NONE);
    frame(16'h0040, 48'h020000000001, 4'h4, 16'h40, 1'h1, CAUSE_ERRORED);
    frame(16'h0800, 48'h020000000001, 4'h3, 16'h0, 1'h1, CAUSE_VLAN);
    wr(8'h02, 8'h02);
    frame(16'h8808, 48'h020000000001, 4'h0, 16'h0, 1'h1, CAUSE_FLOW_CTRL);
    frame(16'h0800, 48'h0180C2000001, 4'h0, 16'h0, 1'h1, CAUSE_FLOW_CTRL);
    frame(16'h0800, 48'h020000000001, 4'h8, 16'h0, 1'h0, CAUSE_NONE);
    wr(8'h04, 8'h00);
    frame(16'h0800, 48'h020000000001, 4'h3, 16'h0, 1'h0, CAUSE_NONE);
    frame(16'h0800, 48'h020000000001, 4'h2, 16'h0, 1'h1, CAUSE_VLAN);
    wr(8'h03, 8'h88);
    frame(16'h0040, 48'h020000000001, 4'h4, 16'h41, 1'h0, CAUSE_NONE);
    wr(8'h03, 8'h08);
    link_up <= 5'h1F;
    wr(8'h02, 8'h01);
    @(posedge ref_clk);
    link_up <= 5'h1B;
    wait_req(4);
    chk({age_fast_mode, flush_all}, 16'h0003);
    done_pulse();
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h04);
    wait_req(40);
    chk({15'h0000, age_fast_mode}, 16'h0000);
    chk({15'h0000, n >= 12}, 16'h0001);
    done_pulse();
    wr(8'h03, 8'h06);
    wait_req(40);
    done_pulse();
    wait_req(8);
    chk({15'h0000, age_fast_mode}, 16'h0001);
    wr(8'h03, 8'h00);
    done_pulse();
    tally_and_finish();
  end
endmodule : test_switch_global_frame_policy

bind switch_global_frame_policy switch_global_frame_policy_assertions #(.PORTS(PORTS)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .frm_valid(frm_valid), .vrd_valid(vrd_valid), .link_up(link_up),
  .autonegotiation_tx_pause(autonegotiation_tx_pause), .tx_pause_en(tx_pause_en),
  .rx_pause_en(rx_pause_en), .aggressive_backoff(aggressive_backoff),
  .age_pass_req(age_pass_req), .age_fast_mode(age_fast_mode), .flush_all(flush_all),
  .age_pass_done(age_pass_done));
